/* File: rtl/mmd_decoder.sv */
// Program and data space address decoder with shared RAM and vector logic.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Each vector slot takes two words, so a vector reaches only 19 address bits.
// - Vectors 38 to 44 serve timer, converter and PWM events, levels 0 to 2.
// - Vector 45 is the low priority software request, below every settable level.
// - All addresses in both spaces are word addresses, one word each.
// - Program flash spans word zero upward; boot at zero, watchdog reset at two.
// - Program words 0x8000 to 0x87FF reach the shared RAM.
// - Data words 0 to 0x07FF reach the same RAM, seen from both spaces.
// - With vector base at reset, slots zero and one meet the reset addresses.
// - The 32-bit transfer word spans 0xFFFFFE low and 0xFFFFFF high.
// - Transfer status 0xFFFFFD, lock status 0xFFFFFC, control 0xFFFFA0, gap reserved.
// - Step counter 9E/9F, trace stages 98/99, trace pointer 9A, control 9B.
// - Debug status at 0xFFFF9D and peripheral base pointer at 0xFFFF9C.
// - Breakpoint control, addresses and mask take word pairs; counter at 0xFFFF8E.
// - External signal control at 0xFFFF8A; 0xFFFF89 down to 0xFFFF00 reserved.
// - A vector slot sits at vector base plus twice the vector number.
// - Higher levels are served first; within a level the lowest vector wins.
module mmd_decoder (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [23:0] prog_addr,
    input wire logic prog_rd,
    input wire logic prog_wr,
    input wire logic [15:0] prog_wdata,
    output logic [15:0] prog_rdata,
    output logic prog_rvalid,
    input wire logic [23:0] data_addr,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [15:0] data_wdata,
    output logic [15:0] data_rdata,
    output logic data_rvalid,
    output logic flash_sel,
    output logic flash_we,
    output logic [12:0] flash_addr,
    output logic [15:0] flash_wdata,
    input wire logic [15:0] flash_rdata,
    output logic periph_sel,
    output logic periph_we,
    output logic [11:0] periph_addr,
    output logic [15:0] periph_wdata,
    input wire logic [15:0] periph_rdata,
    output logic debug_sel,
    output logic debug_we,
    output mmd_pkg::mmd_dbg_reg_t debug_reg,
    output logic debug_upper,
    output logic [15:0] debug_wdata,
    input wire logic [15:0] debug_rdata,
    input wire logic vector_base_load,
    input wire logic [23:0] vector_base_in,
    output logic [23:0] vector_base,
    output logic [23:0] reset_fetch_addr,
    output logic [23:0] wdog_fetch_addr,
    output logic vector_overlays_reset,
    input wire logic [6:0] irq_pending,
    input wire logic [13:0] irq_prio,
    input wire logic low_priority_software_interrupt,
    output logic irq_valid,
    output logic [6:0] irq_vector,
    output logic [23:0] irq_slot_addr,
    input wire logic vec_word_valid,
    input wire logic [15:0] vec_word_hi,
    input wire logic [15:0] vec_word_lo,
    output logic [18:0] vec_target
);
    import mmd_pkg::*;

    typedef struct packed {
        mmd_dbg_reg_t reg_id;
        logic upper;
    } mmd_dbg_hit_t;

    // Inclusive word range test shared by both spaces.
    function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                      input logic [23:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // Maps the low byte of a debug window word to its register and half.
    function automatic mmd_dbg_hit_t dbg_decode(input logic [7:0] ofs);
        mmd_dbg_hit_t h;
        h = '{reg_id: DBG_NONE, upper: 1'b0};
        unique case (ofs)
            OFS_XFER_HI: h = '{reg_id: DBG_TRANSFER_WORD, upper: 1'b1};
            OFS_XFER_LO: h = '{reg_id: DBG_TRANSFER_WORD, upper: 1'b0};
            OFS_XFER_STATUS: h.reg_id = DBG_TRANSFER_STATUS;
            OFS_CORE_LOCK: h.reg_id = DBG_CORE_LOCK_STATUS;
            OFS_CONTROL: h.reg_id = DBG_CONTROL;
            OFS_STEP_HI: h = '{reg_id: DBG_STEP_COUNTER, upper: 1'b1};
            OFS_STEP_LO: h = '{reg_id: DBG_STEP_COUNTER, upper: 1'b0};
            OFS_STATUS: h.reg_id = DBG_STATUS;
            OFS_PERIPH_BASE: h.reg_id = DBG_PERIPH_BASE;
            OFS_TRACE_CONTROL: h.reg_id = DBG_TRACE_CONTROL;
            OFS_TRACE_POINTER: h.reg_id = DBG_TRACE_POINTER;
            OFS_TRACE_HI: h = '{reg_id: DBG_TRACE_STAGES, upper: 1'b1};
            OFS_TRACE_LO: h = '{reg_id: DBG_TRACE_STAGES, upper: 1'b0};
            OFS_BKPT_CTRL_HI: h = '{reg_id: DBG_BKPT_CONTROL, upper: 1'b1};
            OFS_BKPT_CTRL_LO: h = '{reg_id: DBG_BKPT_CONTROL, upper: 1'b0};
            OFS_BKPT_A1_HI: h = '{reg_id: DBG_BKPT_ADDR_ONE, upper: 1'b1};
            OFS_BKPT_A1_LO: h = '{reg_id: DBG_BKPT_ADDR_ONE, upper: 1'b0};
            OFS_BKPT_A2_HI: h = '{reg_id: DBG_BKPT_ADDR_TWO, upper: 1'b1};
            OFS_BKPT_A2_LO: h = '{reg_id: DBG_BKPT_ADDR_TWO, upper: 1'b0};
            OFS_BKPT_MASK_HI: h = '{reg_id: DBG_BKPT_MASK, upper: 1'b1};
            OFS_BKPT_MASK_LO: h = '{reg_id: DBG_BKPT_MASK, upper: 1'b0};
            OFS_BKPT_COUNTER: h.reg_id = DBG_BKPT_COUNTER;
            OFS_EXT_SIGNAL: h.reg_id = DBG_EXT_SIGNAL;
            default: h.reg_id = DBG_NONE;
        endcase
        return h;
    endfunction

    mmd_ram_if ram_bus ();

    // Program space decode; every address is one 16-bit word.
    wire logic p_hit_flash = in_range(prog_addr, FLASH_LO, FLASH_HI);
    wire logic p_hit_ram = in_range(prog_addr, PRAM_LO, PRAM_HI);
    wire logic p_access = prog_rd | prog_wr;
    wire mmd_target_t p_target = !p_access ? TGT_NONE :
                                 p_hit_flash ? TGT_FLASH :
                                 p_hit_ram ? TGT_RAM : TGT_NONE;

    // Data space decode.
    wire logic d_hit_ram = in_range(data_addr, DRAM_LO, DRAM_HI);
    wire logic d_hit_periph = in_range(data_addr, PERIPH_LO, PERIPH_HI);
    wire logic d_hit_debug = in_range(data_addr, DEBUG_LO, DEBUG_HI);
    wire mmd_dbg_hit_t d_dbg = dbg_decode(data_addr[7:0]);
    wire logic d_dbg_valid = d_hit_debug && (d_dbg.reg_id != DBG_NONE);
    wire logic d_access = data_rd | data_wr;
    wire mmd_target_t d_target = !d_access ? TGT_NONE :
                                 d_hit_ram ? TGT_RAM :
                                 d_hit_periph ? TGT_PERIPH :
                                 d_dbg_valid ? TGT_DEBUG : TGT_NONE;

    // Target strobes; reserved words raise none of them.
    assign flash_sel = (p_target == TGT_FLASH);
    assign flash_we = flash_sel & prog_wr;
    assign flash_addr = prog_addr[FLASH_AW-1:0];
    assign flash_wdata = prog_wdata;

    assign periph_sel = (d_target == TGT_PERIPH);
    assign periph_we = periph_sel & data_wr;
    assign periph_addr = data_addr[PERIPH_AW-1:0];
    assign periph_wdata = data_wdata;

    assign debug_sel = (d_target == TGT_DEBUG);
    assign debug_we = debug_sel & data_wr;
    assign debug_reg = debug_sel ? d_dbg.reg_id : DBG_NONE;
    assign debug_upper = debug_sel & d_dbg.upper;
    assign debug_wdata = data_wdata;

    // Both spaces land on one physical array with the same word index.
    assign ram_bus.p_addr = prog_addr[RAM_AW-1:0];
    assign ram_bus.p_we = (p_target == TGT_RAM) & prog_wr;
    assign ram_bus.p_wdata = prog_wdata;
    assign ram_bus.d_addr = data_addr[RAM_AW-1:0];
    assign ram_bus.d_we = (d_target == TGT_RAM) & data_wr;
    assign ram_bus.d_wdata = data_wdata;

    mmd_shared_ram u_ram (
        .clk(clk),
        .ram(ram_bus.mem)
    );

    // Read returns one cycle after the request for every target.
    mmd_target_t p_rd_tgt;
    mmd_target_t d_rd_tgt;
    logic [15:0] p_ext_q;
    logic [15:0] d_ext_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p_rd_tgt <= TGT_NONE;
            d_rd_tgt <= TGT_NONE;
            prog_rvalid <= 1'b0;
            data_rvalid <= 1'b0;
        end else begin
            p_rd_tgt <= prog_rd ? p_target : TGT_NONE;
            d_rd_tgt <= data_rd ? d_target : TGT_NONE;
            prog_rvalid <= prog_rd;
            data_rvalid <= data_rd;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p_ext_q <= 16'h0000;
            d_ext_q <= 16'h0000;
        end else begin
            p_ext_q <= flash_sel ? flash_rdata : 16'h0000;
            d_ext_q <= periph_sel ? periph_rdata : (debug_sel ? debug_rdata : 16'h0000);
        end
    end

    // Reserved reads come back as zero.
    assign prog_rdata = (p_rd_tgt == TGT_RAM) ? ram_bus.p_q :
                        (p_rd_tgt == TGT_FLASH) ? p_ext_q : 16'h0000;
    assign data_rdata = (d_rd_tgt == TGT_RAM) ? ram_bus.d_q :
                        (d_rd_tgt == TGT_NONE) ? 16'h0000 : d_ext_q;

    // Vector base and the two reset fetch addresses.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vector_base <= VECTOR_BASE_RESET;
        end else if (vector_base_load) begin
            vector_base <= vector_base_in;
        end
    end

    assign reset_fetch_addr = BOOT_ADDR;
    assign wdog_fetch_addr = WDOG_ADDR;
    wire logic [23:0] slot_one = vector_base + 24'(SLOT_WORDS);
    assign vector_overlays_reset = (vector_base == BOOT_ADDR) && (slot_one == WDOG_ADDR);

    mmd_irq_arbiter u_arb (
        .clk(clk),
        .nrst(nrst),
        .irq_pending(irq_pending),
        .irq_prio(irq_prio),
        .low_priority_software_interrupt(low_priority_software_interrupt),
        .vector_base(vector_base),
        .irq_valid(irq_valid),
        .irq_vector(irq_vector),
        .irq_slot_addr(irq_slot_addr)
    );

    // A two-word slot carries only 19 target bits: three from the high word.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vec_target <= 19'h00000;
        end else if (vec_word_valid) begin
            vec_target <= {vec_word_hi[VEC_TARGET_W-17:0], vec_word_lo};
        end
    end
endmodule
`default_nettype wire

/* File: rtl/mmd_pkg.sv */
// Package with address map, vector layout and debug register codes of the decoder.
package mmd_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int RAM_AW = 11;
    localparam int RAM_WORDS = 2048;
    localparam int FLASH_AW = 13;
    localparam int PERIPH_AW = 12;

    localparam logic [23:0] FLASH_LO = 24'h000000;
    localparam logic [23:0] FLASH_HI = 24'h001FFF;
    localparam logic [23:0] PRAM_LO = 24'h008000;
    localparam logic [23:0] PRAM_HI = 24'h0087FF;
    localparam logic [23:0] DRAM_LO = 24'h000000;
    localparam logic [23:0] DRAM_HI = 24'h0007FF;
    localparam logic [23:0] PERIPH_LO = 24'h00F000;
    localparam logic [23:0] PERIPH_HI = 24'h00FFFF;
    localparam logic [23:0] DEBUG_LO = 24'hFFFF00;
    localparam logic [23:0] DEBUG_HI = 24'hFFFFFF;
    localparam logic [23:0] BOOT_ADDR = 24'h000000;
    localparam logic [23:0] WDOG_ADDR = 24'h000002;
    localparam logic [23:0] VECTOR_BASE_RESET = 24'h000000;

    localparam int SLOT_WORDS = 2;
    localparam int VEC_TARGET_W = 19;
    localparam int NUM_SET = 7;
    localparam logic [6:0] VEC_FIRST = 7'h26;
    localparam logic [6:0] VEC_SW_LOW = 7'h2D;
    localparam logic [1:0] PRIO_MAX = 2'h2;

    localparam logic [7:0] OFS_XFER_HI = 8'hFF;
    localparam logic [7:0] OFS_XFER_LO = 8'hFE;
    localparam logic [7:0] OFS_XFER_STATUS = 8'hFD;
    localparam logic [7:0] OFS_CORE_LOCK = 8'hFC;
    localparam logic [7:0] OFS_CONTROL = 8'hA0;
    localparam logic [7:0] OFS_STEP_HI = 8'h9F;
    localparam logic [7:0] OFS_STEP_LO = 8'h9E;
    localparam logic [7:0] OFS_STATUS = 8'h9D;
    localparam logic [7:0] OFS_PERIPH_BASE = 8'h9C;
    localparam logic [7:0] OFS_TRACE_CONTROL = 8'h9B;
    localparam logic [7:0] OFS_TRACE_POINTER = 8'h9A;
    localparam logic [7:0] OFS_TRACE_HI = 8'h99;
    localparam logic [7:0] OFS_TRACE_LO = 8'h98;
    localparam logic [7:0] OFS_BKPT_CTRL_HI = 8'h97;
    localparam logic [7:0] OFS_BKPT_CTRL_LO = 8'h96;
    localparam logic [7:0] OFS_BKPT_A1_HI = 8'h95;
    localparam logic [7:0] OFS_BKPT_A1_LO = 8'h94;
    localparam logic [7:0] OFS_BKPT_A2_HI = 8'h93;
    localparam logic [7:0] OFS_BKPT_A2_LO = 8'h92;
    localparam logic [7:0] OFS_BKPT_MASK_HI = 8'h91;
    localparam logic [7:0] OFS_BKPT_MASK_LO = 8'h90;
    localparam logic [7:0] OFS_BKPT_COUNTER = 8'h8E;
    localparam logic [7:0] OFS_EXT_SIGNAL = 8'h8A;

    typedef enum logic [2:0] {
        TGT_NONE = 3'b000,
        TGT_FLASH = 3'b001,
        TGT_RAM = 3'b010,
        TGT_PERIPH = 3'b011,
        TGT_DEBUG = 3'b100
    } mmd_target_t;

    typedef enum logic [4:0] {
        DBG_NONE = 5'h00,
        DBG_TRANSFER_WORD = 5'h01,
        DBG_TRANSFER_STATUS = 5'h02,
        DBG_CORE_LOCK_STATUS = 5'h03,
        DBG_CONTROL = 5'h04,
        DBG_STEP_COUNTER = 5'h05,
        DBG_STATUS = 5'h06,
        DBG_PERIPH_BASE = 5'h07,
        DBG_TRACE_CONTROL = 5'h08,
        DBG_TRACE_POINTER = 5'h09,
        DBG_TRACE_STAGES = 5'h0A,
        DBG_BKPT_CONTROL = 5'h0B,
        DBG_BKPT_ADDR_ONE = 5'h0C,
        DBG_BKPT_ADDR_TWO = 5'h0D,
        DBG_BKPT_MASK = 5'h0E,
        DBG_BKPT_COUNTER = 5'h0F,
        DBG_EXT_SIGNAL = 5'h10
    } mmd_dbg_reg_t;

endpackage

/* File: rtl/mmd_ram_if.sv */
// Interface carrying both ports of the shared RAM.
`timescale 1ns/1ps
`default_nettype none
interface mmd_ram_if;
    logic [10:0] p_addr;
    logic p_we;
    logic [15:0] p_wdata;
    logic [15:0] p_q;
    logic [10:0] d_addr;
    logic d_we;
    logic [15:0] d_wdata;
    logic [15:0] d_q;
    modport ctrl (output p_addr, p_we, p_wdata, d_addr, d_we, d_wdata, input p_q, d_q);
    modport mem (input p_addr, p_we, p_wdata, d_addr, d_we, d_wdata, output p_q, d_q);
endinterface
`default_nettype wire

/* File: rtl/mmd_shared_ram.sv */
// Dual port word RAM shared by program and data space.
`timescale 1ns/1ps
`default_nettype none
module mmd_shared_ram (
    input wire logic clk,
    mmd_ram_if.mem ram
);
    import mmd_pkg::*;

    logic [15:0] mem [RAM_WORDS];

    // Both ports hit one array; on a same-word write the data port lands last.
    always_ff @(posedge clk) begin
        if (ram.p_we) begin
            mem[ram.p_addr] <= ram.p_wdata;
        end
        if (ram.d_we) begin
            mem[ram.d_addr] <= ram.d_wdata;
        end
        ram.p_q <= mem[ram.p_addr];
        ram.d_q <= mem[ram.d_addr];
    end
endmodule
`default_nettype wire

/* File: rtl/mmd_irq_arbiter.sv */
// Priority arbiter for vectors 38 to 45 and their slot addresses.
`timescale 1ns/1ps
`default_nettype none
module mmd_irq_arbiter (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [6:0] irq_pending,
    input wire logic [13:0] irq_prio,
    input wire logic low_priority_software_interrupt,
    input wire logic [23:0] vector_base,
    output logic irq_valid,
    output logic [6:0] irq_vector,
    output logic [23:0] irq_slot_addr
);
    import mmd_pkg::*;

    // Settable levels above the top settable value are held at it.
    function automatic logic [1:0] clamp_level(input logic [1:0] lvl);
        return (lvl > PRIO_MAX) ? PRIO_MAX : lvl;
    endfunction

    logic found;
    logic [2:0] best;
    logic [1:0] best_lvl;
    logic [6:0] next_vector;

    always_comb begin
        found = 1'b0;
        best = 3'h0;
        best_lvl = 2'h0;
        for (int i = 0; i < NUM_SET; i++) begin
            if (irq_pending[i] && (!found || clamp_level(irq_prio[2*i +: 2]) > best_lvl)) begin
                found = 1'b1;
                best = 3'(i);
                best_lvl = clamp_level(irq_prio[2*i +: 2]);
            end
        end
    end

    // The low priority software request only wins when nothing else waits.
    assign next_vector = found ? VEC_FIRST + 7'(best) : VEC_SW_LOW;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_valid <= 1'b0;
            irq_vector <= 7'h00;
            irq_slot_addr <= 24'h000000;
        end else begin
            irq_valid <= found | low_priority_software_interrupt;
            irq_vector <= next_vector;
            irq_slot_addr <= vector_base + 24'({next_vector, 1'b0});
        end
    end
endmodule
`default_nettype wire

/* File: verification/mmd_decoder_monitor.sv */
// Checker watching the decoder ports.
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_monitor
    import mmd_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [23:0] prog_addr,
    input wire logic prog_rd,
    input wire logic prog_wr,
    input wire logic flash_sel,
    input wire logic flash_we,
    input wire logic [12:0] flash_addr,
    input wire logic [23:0] data_addr,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic data_rvalid,
    input wire logic [15:0] data_rdata,
    input wire logic periph_sel,
    input wire logic periph_we,
    input wire logic debug_sel,
    input wire logic debug_we,
    input wire mmd_pkg::mmd_dbg_reg_t debug_reg,
    input wire logic debug_upper,
    input wire logic [23:0] vector_base,
    input wire logic [23:0] wdog_fetch_addr,
    input wire logic vector_overlays_reset,
    input wire logic [6:0] irq_pending,
    input wire logic low_priority_software_interrupt,
    input wire logic irq_valid,
    input wire logic [6:0] irq_vector,
    input wire logic [23:0] irq_slot_addr,
    input wire logic vec_word_valid,
    input wire logic [15:0] vec_word_hi,
    input wire logic [15:0] vec_word_lo,
    input wire logic [18:0] vec_target
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [18:0] exp_tgt;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            exp_tgt <= 19'h00000;
        end else begin
            exp_tgt <= {vec_word_hi[2:0], vec_word_lo};
        end
    end
    flash_map_a: assert property ((prog_rd || prog_wr) |->
        flash_sel == (prog_addr <= FLASH_HI) && flash_addr == prog_addr[12:0])
        else $error("flash select wrong");
    periph_map_a: assert property ((data_rd || data_wr) |->
        periph_sel == (data_addr >= PERIPH_LO && data_addr <= PERIPH_HI))
        else $error("peripheral select wrong");
    dbg_gap_a: assert property ((data_rd || data_wr) && data_addr >= 24'hFFFF00
        && data_addr <= 24'hFFFF89 |-> !debug_sel) else $error("low debug gap selected");
    dbg_hole_a: assert property ((data_rd || data_wr) && data_addr >= 24'hFFFFA1
        && data_addr <= 24'hFFFFFB |-> !debug_sel) else $error("high debug gap selected");
    xfer_pair_a: assert property (data_rd && data_addr[23:1] == 23'h7FFFFF |->
        debug_sel && debug_reg == DBG_TRANSFER_WORD && debug_upper == data_addr[0])
        else $error("transfer word pair wrong");
    rsv_read_a: assert property (data_rd && data_addr >= 24'h000800
        && data_addr <= 24'h00EFFF |=> data_rvalid && data_rdata == 16'h0000)
        else $error("reserved read not zero");
    slot_sum_a: assert property (irq_valid && $stable(vector_base) |->
        irq_slot_addr == vector_base + {16'h0000, irq_vector, 1'b0})
        else $error("slot address wrong");
    low_prio_a: assert property (low_priority_software_interrupt && irq_pending == 7'h00 |=>
        irq_valid && irq_vector == VEC_SW_LOW) else $error("low priority vector wrong");
    set_range_a: assert property (irq_pending != 7'h00 |=> irq_valid
        && irq_vector >= VEC_FIRST && irq_vector <= 7'h2C) else $error("vector range wrong");
    tgt_wide_a: assert property (vec_word_valid |=> vec_target == exp_tgt)
        else $error("vector target wrong");
    overlay_a: assert property (vector_overlays_reset == (vector_base == 24'h000000)
        && wdog_fetch_addr == 24'h000002) else $error("reset overlay wrong");
    we_gate_a: assert property (flash_we == (flash_sel && prog_wr)
        && periph_we == (periph_sel && data_wr) && debug_we == (debug_sel && data_wr))
        else $error("strobe wrong");
endmodule
`default_nettype wire

/* File: verification/mmd_target_model.sv */
// Far-side targets returning address-derived read words.
`timescale 1ns/1ps
`default_nettype none
module mmd_target_model (
    input wire logic clk,
    input wire logic flash_sel,
    input wire logic [12:0] flash_addr,
    input wire logic periph_sel,
    input wire logic [11:0] periph_addr,
    input wire logic debug_sel,
    input wire logic [4:0] debug_reg,
    input wire logic debug_upper,
    output logic [15:0] flash_rdata,
    output logic [15:0] periph_rdata,
    output logic [15:0] debug_rdata
);
    logic [15:0] junk = 16'h1234;
    always @(posedge clk) junk <= junk + 16'h3C5B;
    assign flash_rdata = flash_sel ? {3'h5, flash_addr} : junk;
    assign periph_rdata = periph_sel ? {4'hC, periph_addr} : ~junk;
    assign debug_rdata = debug_sel ? {debug_upper, 10'h155, debug_reg} : junk ^ 16'h0F0F;
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench of the address decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mmd_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic prog_rd = 1'b0, prog_wr = 1'b0, data_rd = 1'b0, data_wr = 1'b0;
    logic vector_base_load = 1'b0, low_priority_software_interrupt = 1'b0, vec_word_valid = 1'b0;
    logic [23:0] prog_addr = '0, data_addr = '0, vector_base_in = '0;
    logic [15:0] prog_wdata = '0, data_wdata = '0, vec_word_hi = '0, vec_word_lo = '0;
    logic [6:0] irq_pending = '0;
    logic [13:0] irq_prio = '0;
    logic [15:0] prog_rdata, data_rdata, flash_wdata, periph_wdata, debug_wdata;
    logic [15:0] flash_rdata, periph_rdata, debug_rdata;
    logic prog_rvalid, data_rvalid, flash_sel, flash_we, periph_sel, periph_we;
    logic debug_sel, debug_we, debug_upper, vector_overlays_reset, irq_valid;
    logic [12:0] flash_addr;
    logic [11:0] periph_addr;
    mmd_dbg_reg_t debug_reg;
    logic [23:0] vector_base, reset_fetch_addr, wdog_fetch_addr, irq_slot_addr;
    logic [6:0] irq_vector;
    logic [18:0] vec_target;
    logic [15:0] qp[$], qd[$], ram [0:2047], d;
    logic [30:0] qi[$];
    logic [23:0] a, cur_base = '0;
    int error_cnt = 0, n_tests = 0;
    logic [7:0] dofs [23] = '{8'hFF, 8'hFE, 8'hFD, 8'hFC, 8'hA0, 8'h9F, 8'h9E, 8'h9D, 8'h9C,
        8'h9B, 8'h9A, 8'h99, 8'h98, 8'h97, 8'h96, 8'h95, 8'h94, 8'h93, 8'h92, 8'h91, 8'h90,
        8'h8E, 8'h8A};
    logic [5:0] dcode [23] = '{6'h21, 6'h01, 6'h02, 6'h03, 6'h04, 6'h25, 6'h05, 6'h06, 6'h07,
        6'h08, 6'h09, 6'h2A, 6'h0A, 6'h2B, 6'h0B, 6'h2C, 6'h0C, 6'h2D, 6'h0D, 6'h2E, 6'h0E,
        6'h0F, 6'h10};
    logic [24:0] bnd [16] = '{25'h1000000, 25'h1000002, 25'h1001FFF, 25'h1002000, 25'h1007FFF,
        25'h1008000, 25'h10087FF, 25'h1008800, 25'h1FFFFFF, 25'h00007FF, 25'h0000800,
        25'h000EFFF, 25'h000F000, 25'h000FFFF, 25'h0010000, 25'h0FFFEFF};
    mmd_decoder mmd_decoder_i (.*);
    mmd_target_model mmd_target_model_i (.*);
    always #10 clk = ~clk;
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_vec(input logic [30:0] got, input logic [30:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [5:0] dbg_code(input logic [7:0] o);
        for (int k = 0; k < 23; k++) begin
            if (dofs[k] == o) return dcode[k];
        end
        return 6'h00;
    endfunction
    function automatic logic [15:0] exp_rd(input bit p, input logic [23:0] x);
        logic [5:0] c;
        c = dbg_code(x[7:0]);
        if (p && x <= 24'h001FFF) return {3'h5, x[12:0]};
        if (p && x >= 24'h008000 && x <= 24'h0087FF) return ram[x[10:0]];
        if (!p && x <= 24'h0007FF) return ram[x[10:0]];
        if (!p && x >= 24'h00F000 && x <= 24'h00FFFF) return {4'hC, x[11:0]};
        if (!p && x >= 24'hFFFF00 && c != 6'h00) return {c[5], 10'h155, c[4:0]};
        return 16'h0000;
    endfunction
    task automatic bus(input bit p, input bit w, input logic [23:0] x, input logic [15:0] v);
        @(posedge clk);
        prog_rd <= p && !w;
        prog_wr <= p && w;
        data_rd <= !p && !w;
        data_wr <= !p && w;
        prog_addr <= x;
        data_addr <= x;
        prog_wdata <= v;
        data_wdata <= v;
        if (w && ((p && x >= 24'h008000 && x <= 24'h0087FF) || (!p && x <= 24'h0007FF)))
            ram[x[10:0]] = v;
        if (!w && p) qp.push_back(exp_rd(1'b1, x));
        if (!w && !p) qd.push_back(exp_rd(1'b0, x));
    endtask
    task automatic idle();
        @(posedge clk);
        prog_rd <= 1'b0;
        prog_wr <= 1'b0;
        data_rd <= 1'b0;
        data_wr <= 1'b0;
    endtask
    task automatic irq(input logic [6:0] p, input logic [13:0] pr, input bit s);
        logic [1:0] best, lv;
        logic [6:0] v;
        best = 2'h0;
        v = 7'h00;
        for (int i = 6; i >= 0; i--) begin
            lv = (pr[2*i+:2] == 2'h3) ? 2'h2 : pr[2*i+:2];
            if (p[i] && (v == 7'h00 || lv >= best)) begin
                best = lv;
                v = 7'(38 + i);
            end
        end
        if (v == 7'h00 && s) v = VEC_SW_LOW;
        if (v != 7'h00) qi.push_back({v, cur_base + {16'h0000, v, 1'b0}});
        @(posedge clk);
        irq_pending <= p;
        irq_prio <= pr;
        low_priority_software_interrupt <= s;
        @(posedge clk);
        irq_pending <= 7'h00;
        low_priority_software_interrupt <= 1'b0;
    endtask
    task automatic load_base(input logic [23:0] b);
        @(posedge clk);
        vector_base_load <= 1'b1;
        vector_base_in <= b;
        cur_base = b;
        @(posedge clk);
        vector_base_load <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        if (prog_rvalid === 1'b1) cmp_word(prog_rdata, qp.pop_front());
        if (data_rvalid === 1'b1) cmp_word(data_rdata, qd.pop_front());
        if (irq_valid === 1'b1) cmp_vec({irq_vector, irq_slot_addr}, qi.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h8e5c6863));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        cmp_vec({7'h00, vector_base}, 31'h0);
        for (int i = 0; i < 8; i++) begin
            a = 24'($urandom_range(2047));
            d = 16'($urandom);
            bus(i[0], 1'b1, i[0] ? 24'h008000 + a : a, d);
            bus(!i[0], 1'b0, i[0] ? a : 24'h008000 + a, 16'h0000);
        end
        $display("test shared ram done");
        bus(1'b0, 1'b1, 24'h000000, 16'h1234);
        bus(1'b0, 1'b1, 24'h0007FF, 16'h5A5A);
        bus(1'b0, 1'b1, 24'h000800, 16'hFFFF);
        bus(1'b1, 1'b1, 24'h008800, 16'hFFFF);
        bus(1'b1, 1'b1, 24'h000002, 16'hBEEF);
        for (int k = 0; k < 16; k++) bus(bnd[k][24], 1'b0, bnd[k][23:0], 16'h0000);
        $display("test address map done");
        for (int o = 0; o < 256; o++) bus(1'b0, 1'b0, {16'hFFFF, 8'(o)}, 16'h0000);
        idle();
        $display("test debug window done");
        for (int i = 0; i < 7; i++) irq(7'(1 << i), 14'($urandom), 1'b0);
        irq(7'h00, 14'h0000, 1'b1);
        irq(7'h40, 14'h0000, 1'b1);
        for (int i = 0; i < 24; i++) begin
            if (i % 6 == 0) load_base(24'($urandom));
            irq(7'($urandom), 14'($urandom), 1'($urandom));
        end
        $display("test interrupt arbiter done");
        for (int i = 0; i < 8; i++) begin
            d = 16'($urandom);
            @(posedge clk);
            vec_word_valid <= 1'b1;
            vec_word_hi <= d;
            vec_word_lo <= ~d;
            @(posedge clk);
            vec_word_valid <= 1'b0;
            @(negedge clk);
            cmp_vec({12'h000, vec_target}, {12'h000, d[2:0], ~d});
        end
        $display("test vector target done");
        nrst <= 1'b0;
        cur_base = 24'h000000;
        repeat (2) @(posedge clk);
        cmp_vec({7'h00, vector_base}, 31'h0);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
bind mmd_decoder mmd_decoder_monitor mmd_decoder_monitor_i (.*);
`default_nettype wire
